// File: ubac_pkg.sv
// Constants for the baud, auto-baud, checksum and collision support block
package ubac_pkg;
  localparam int AW = 3;
  localparam int DW = 8;
  // Register offsets
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_DIV_LO = 3'h1;
  localparam logic [2:0] ADDR_DIV_HI = 3'h2;
  localparam logic [2:0] ADDR_TX_SUM = 3'h3;
  localparam logic [2:0] ADDR_RX_SUM = 3'h4;
  localparam logic [2:0] ADDR_STATUS = 3'h5;
  localparam logic [2:0] ADDR_CTRL2 = 3'h6;
  // Control fields
  localparam int SPEED_BIT = 7;
  localparam int RATE_EN_BIT = 6;
  localparam int TX_EN_BIT = 5;
  localparam int RX_EN_BIT = 4;
  localparam int MODE_LSB = 0;
  localparam int CSUM_EN_BIT = 0;
  localparam int COLL_IE_BIT = 1;
  localparam int HOLD_SEL_TX_BIT = 2;
  // Status fields
  localparam int ST_RATE_DONE = 0;
  localparam int ST_RATE_OVF = 1;
  localparam int ST_COLL = 2;
  localparam int ST_CERR = 3;
  localparam int ST_RX_IDLE = 4;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0000;
  localparam logic [7:0] SUM_RST = 8'h00;
  // Modes
  localparam logic [3:0] MODE_ASYNC8 = 4'h0;
  localparam logic [3:0] MODE_ASYNC7 = 4'h1;
  localparam logic [3:0] MODE_DALI = 4'h8;
  localparam logic [3:0] MODE_LIN = 4'hc;
  // Timing counts in system clocks, baud ticks or line edges
  localparam logic [4:0] BITS_HI = 5'h04;
  localparam logic [4:0] BITS_LO = 5'h10;
  localparam logic [6:0] RATE_PRE_HI = 7'h1f;
  localparam logic [6:0] RATE_PRE_LO = 7'h7f;
  localparam logic [2:0] RATE_EDGES = 3'h5;
  typedef enum logic [3:0] {
    RATE_IDLE = 4'b0001,
    RATE_WAIT = 4'b0010,
    RATE_MEAS = 4'b0100,
    RATE_TAIL = 4'b1000
  } ubac_rate_t;
endpackage

// File: ubac_csum.sv
// Eight-bit checksum adder with end-around carry
`timescale 1ns/1ps
module ubac_csum (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Control
  input wire logic en_i,
  input wire logic load_i,
  input wire logic [7:0] load_data_i,
  // Completed bytes
  input wire logic byte_done_i,
  input wire logic [7:0] byte_i,
  // Sum
  output logic [7:0] sum_o
);
  logic [8:0] raw_sum;
  logic [7:0] next_sum;

  assign raw_sum = {1'b0, sum_o} + {1'b0, byte_i};
  assign next_sum = raw_sum[7:0] + {7'h00, raw_sum[8]};

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sum_o <= ubac_pkg::SUM_RST;
    end else if (ce_i) begin
      if (load_i) begin
        sum_o <= load_data_i;
      end else if (en_i && byte_done_i) begin
        sum_o <= next_sum;
      end
    end
  end
endmodule

// File: ubac_top.sv
// Baud generator, auto-baud, checksum, collision and activity support for a UART
// Behaviour
// - Checksum error flag only in LIN mode.
// - Collision check runs whenever receiver and transmitter enabled.
// - Mismatched looped-back word sets collision flag, interrupt.
// - DALI missing mid-bit transition also flags collision.
// - Line edges restart hold-off timer.
// - Free-running 16-bit baud timer, divisor sets period.
// - Bit rate is clock over 4(n+1) or 16(n+1).
// - Divisor write clears baud timer at once.
// - Auto-baud in 8-bit async and LIN only.
// - First fall starts count, receiver held idle.
// - Fifth fall loads divisor, clears enable, sets done.
// - Idle drops on first fall, returns fifth rise.
// - Measure counter ticks every 32 or 128 clocks.
// - Visible divisor kept until measurement completes.
// - Enabled adders add each byte with carry.
// - Overflow flagged, divisor kept, done at fifth fall.
// - Four or sixteen baud ticks per bit.
`timescale 1ns/1ps
module ubac_top (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Register port
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Serial pins
  input wire logic rx_pin_i,
  input wire logic tx_pin_i,
  // Neighbouring UART logic
  input wire logic tx_byte_done_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic rx_byte_done_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic tx_active_i,
  input wire logic dali_midbit_miss_i,
  input wire logic lin_sync_start_i,
  input wire logic lin_checksum_bad_i,
  input wire logic rx_sm_idle_i,
  // Outputs
  output logic baud_tick_o,
  output logic bit_tick_o,
  output logic rx_sm_hold_o,
  output logic receiver_idle_o,
  output logic collision_irq_o,
  output logic holdoff_restart_o
);
  logic [7:0] ctrl;
  logic [7:0] ctrl2;
  logic [15:0] baud_divisor;
  logic [15:0] baud_count;
  logic [4:0] bit_phase;
  logic autobaud_done_flag;
  logic autobaud_overflow_flag;
  logic collision_flag;
  logic checksum_error_flag;
  logic [7:0] tx_checksum_sum;
  logic [7:0] rx_checksum_sum;
  logic [7:0] tx_last;
  logic coll_armed;
  logic rx_s1, rx_s2, rx_s3;
  logic tx_s1, tx_s2, tx_s3;
  ubac_pkg::ubac_rate_t rate_state;
  ubac_pkg::ubac_rate_t next_rate_state;
  logic [16:0] rate_count;
  logic [6:0] rate_pre;
  logic [2:0] rate_falls;
  logic [2:0] rate_rises;
  logic lin_req;

  // Decode
  wire [3:0] mode = ctrl[ubac_pkg::MODE_LSB +: 4];
  wire speed_select = ctrl[ubac_pkg::SPEED_BIT];
  wire autobaud_enable = ctrl[ubac_pkg::RATE_EN_BIT];
  wire checksum_adders_enable = ctrl2[ubac_pkg::CSUM_EN_BIT];
  wire collision_irq_enable = ctrl2[ubac_pkg::COLL_IE_BIT];
  wire mode_lin = (mode == ubac_pkg::MODE_LIN);
  wire mode_dali = (mode == ubac_pkg::MODE_DALI);
  wire wr_ctrl = ce_i && wr_i && (addr_i == ubac_pkg::ADDR_CTRL);
  wire wr_lo = ce_i && wr_i && (addr_i == ubac_pkg::ADDR_DIV_LO);
  wire wr_hi = ce_i && wr_i && (addr_i == ubac_pkg::ADDR_DIV_HI);
  wire wr_txs = ce_i && wr_i && (addr_i == ubac_pkg::ADDR_TX_SUM);
  wire wr_rxs = ce_i && wr_i && (addr_i == ubac_pkg::ADDR_RX_SUM);
  wire wr_stat = ce_i && wr_i && (addr_i == ubac_pkg::ADDR_STATUS);
  wire wr_ctrl2 = ce_i && wr_i && (addr_i == ubac_pkg::ADDR_CTRL2);
  wire rx_fall = rx_s3 && !rx_s2;
  wire rx_rise = !rx_s3 && rx_s2;
  wire tx_edge = tx_s3 ^ tx_s2;
  wire line_edge = ctrl2[ubac_pkg::HOLD_SEL_TX_BIT] ? tx_edge : (rx_fall || rx_rise);

  // Auto-baud
  wire rate_req = autobaud_enable || lin_req;
  wire [6:0] rate_pre_top = speed_select ? ubac_pkg::RATE_PRE_HI : ubac_pkg::RATE_PRE_LO;
  wire rate_pre_wrap = (rate_pre == rate_pre_top);
  wire rate_fifth_fall = (rate_state == ubac_pkg::RATE_MEAS) && rx_fall
                         && (rate_falls == ubac_pkg::RATE_EDGES - 3'h1);
  wire rate_rise_last = rx_rise && (rate_rises == ubac_pkg::RATE_EDGES - 3'h1);
  wire rate_load = rate_fifth_fall && !rate_count[16];
  wire rate_ovf_set = (rate_state == ubac_pkg::RATE_MEAS) && rate_pre_wrap
                      && (rate_count[15:0] == 16'hffff);
  wire rate_busy_next = (next_rate_state == ubac_pkg::RATE_MEAS)
                        || (next_rate_state == ubac_pkg::RATE_TAIL);
  wire rate_sw_ok = (wdata_i[ubac_pkg::MODE_LSB +: 4] == ubac_pkg::MODE_ASYNC8);

  always_comb begin
    next_rate_state = rate_state;
    case (rate_state)
      ubac_pkg::RATE_IDLE: begin
        if (rate_req) begin
          next_rate_state = ubac_pkg::RATE_WAIT;
        end
      end
      ubac_pkg::RATE_WAIT: begin
        if (!rate_req) begin
          next_rate_state = ubac_pkg::RATE_IDLE;
        end else if (rx_fall) begin
          next_rate_state = ubac_pkg::RATE_MEAS;
        end
      end
      ubac_pkg::RATE_MEAS: begin
        if (!rate_req) begin
          next_rate_state = ubac_pkg::RATE_IDLE;
        end else if (rate_fifth_fall) begin
          next_rate_state = ubac_pkg::RATE_TAIL;
        end
      end
      ubac_pkg::RATE_TAIL: begin
        if (rate_rise_last) begin
          next_rate_state = ubac_pkg::RATE_IDLE;
        end
      end
      default: begin
        next_rate_state = ubac_pkg::RATE_IDLE;
      end
    endcase
  end

  // Baud generator
  wire div_write = wr_lo || wr_hi || (ce_i && rate_load);
  wire baud_wrap = (baud_count == baud_divisor);
  wire [4:0] bits_top = (speed_select ? ubac_pkg::BITS_HI : ubac_pkg::BITS_LO) - 5'h01;

  // Collision
  wire coll_check = ctrl[ubac_pkg::RX_EN_BIT] && ctrl[ubac_pkg::TX_EN_BIT];
  wire coll_set = coll_check && ((rx_byte_done_i && coll_armed && (rx_byte_i != tx_last))
                  || (mode_dali && tx_active_i && dali_midbit_miss_i));
  wire cerr_set = mode_lin && lin_checksum_bad_i;
  wire next_coll = coll_set || (collision_flag && !(wr_stat && !wdata_i[ubac_pkg::ST_COLL]));

  // Read mux
  wire [7:0] status = {3'h0, receiver_idle_o, checksum_error_flag, collision_flag,
                       autobaud_overflow_flag, autobaud_done_flag};
  wire [7:0] rd_mux = (addr_i == ubac_pkg::ADDR_CTRL) ? ctrl :
                      (addr_i == ubac_pkg::ADDR_DIV_LO) ? baud_divisor[7:0] :
                      (addr_i == ubac_pkg::ADDR_DIV_HI) ? baud_divisor[15:8] :
                      (addr_i == ubac_pkg::ADDR_TX_SUM) ? tx_checksum_sum :
                      (addr_i == ubac_pkg::ADDR_RX_SUM) ? rx_checksum_sum :
                      (addr_i == ubac_pkg::ADDR_STATUS) ? status :
                      (addr_i == ubac_pkg::ADDR_CTRL2) ? ctrl2 : 8'h00;

  // Pin synchronisers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      {rx_s1, rx_s2, rx_s3} <= 3'h7;
      {tx_s1, tx_s2, tx_s3} <= 3'h7;
    end else if (ce_i) begin
      {rx_s1, rx_s2, rx_s3} <= {rx_pin_i, rx_s1, rx_s2};
      {tx_s1, tx_s2, tx_s3} <= {tx_pin_i, tx_s1, tx_s2};
    end
  end

  // Registers and flags
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl <= ubac_pkg::CTRL_RST;
      ctrl2 <= ubac_pkg::CTRL2_RST;
      baud_divisor <= ubac_pkg::DIV_RST;
      autobaud_done_flag <= 1'b0;
      autobaud_overflow_flag <= 1'b0;
      collision_flag <= 1'b0;
      checksum_error_flag <= 1'b0;
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      rdata_o <= rd_i ? rd_mux : 8'h00;
      if (wr_ctrl) begin
        ctrl <= {wdata_i[7], wdata_i[6] && rate_sw_ok, wdata_i[5:0]};
      end
      if (rate_fifth_fall) begin
        ctrl[ubac_pkg::RATE_EN_BIT] <= 1'b0;
      end
      if (wr_ctrl2) begin
        ctrl2 <= wdata_i;
      end
      if (rate_load) begin
        baud_divisor <= rate_count[15:0];
      end else if (wr_lo) begin
        baud_divisor[7:0] <= wdata_i;
      end else if (wr_hi) begin
        baud_divisor[15:8] <= wdata_i;
      end
      autobaud_done_flag <= rate_fifth_fall
        || (autobaud_done_flag && !(wr_stat && !wdata_i[ubac_pkg::ST_RATE_DONE]));
      autobaud_overflow_flag <= rate_ovf_set
        || (autobaud_overflow_flag && !(wr_stat && !wdata_i[ubac_pkg::ST_RATE_OVF]));
      collision_flag <= next_coll;
      checksum_error_flag <= cerr_set
        || (checksum_error_flag && !(wr_stat && !wdata_i[ubac_pkg::ST_CERR]));
    end
  end

  // Baud timer and bit phase
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      baud_count <= 16'h0000;
      bit_phase <= 5'h00;
      baud_tick_o <= 1'b0;
      bit_tick_o <= 1'b0;
    end else if (ce_i) begin
      baud_tick_o <= !div_write && baud_wrap;
      bit_tick_o <= !div_write && baud_wrap && (bit_phase >= bits_top);
      if (div_write) begin
        baud_count <= 16'h0000;
        bit_phase <= 5'h00;
      end else if (baud_wrap) begin
        baud_count <= 16'h0000;
        bit_phase <= (bit_phase >= bits_top) ? 5'h00 : bit_phase + 5'h01;
      end else begin
        baud_count <= baud_count + 16'h0001;
      end
    end
  end

  // Auto-baud measurement
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rate_state <= ubac_pkg::RATE_IDLE;
      rate_count <= 17'h00000;
      rate_pre <= 7'h00;
      rate_falls <= 3'h0;
      rate_rises <= 3'h0;
      lin_req <= 1'b0;
      rx_sm_hold_o <= 1'b0;
      receiver_idle_o <= 1'b1;
    end else if (ce_i) begin
      rate_state <= next_rate_state;
      rx_sm_hold_o <= rate_busy_next || (next_rate_state == ubac_pkg::RATE_WAIT);
      receiver_idle_o <= rx_sm_idle_i && !rate_busy_next;
      if (rate_fifth_fall || !mode_lin) begin
        lin_req <= 1'b0;
      end else if (lin_sync_start_i) begin
        lin_req <= 1'b1;
      end
      if (rate_state == ubac_pkg::RATE_WAIT) begin
        rate_count <= 17'h00000;
        rate_pre <= 7'h00;
        rate_falls <= {2'h0, rx_fall};
        rate_rises <= 3'h0;
      end else if (rate_state == ubac_pkg::RATE_MEAS) begin
        rate_pre <= rate_pre_wrap ? 7'h00 : rate_pre + 7'h01;
        if (rate_pre_wrap && !rate_count[16]) begin
          rate_count <= rate_count + 17'h00001;
        end
        if (rx_fall) begin
          rate_falls <= rate_falls + 3'h1;
        end
        if (rx_rise) begin
          rate_rises <= rate_rises + 3'h1;
        end
      end else if ((rate_state == ubac_pkg::RATE_TAIL) && rx_rise) begin
        rate_rises <= rate_rises + 3'h1;
      end
    end
  end

  // Collision and line activity
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_last <= 8'h00;
      coll_armed <= 1'b0;
      collision_irq_o <= 1'b0;
      holdoff_restart_o <= 1'b0;
    end else if (ce_i) begin
      if (tx_byte_done_i) begin
        tx_last <= tx_byte_i;
        coll_armed <= coll_check;
      end else if (rx_byte_done_i) begin
        coll_armed <= 1'b0;
      end
      collision_irq_o <= next_coll && collision_irq_enable;
      holdoff_restart_o <= line_edge;
    end
  end

  // Checksum adders
  ubac_csum u_tx_sum (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .en_i(checksum_adders_enable),
    .load_i(wr_txs),
    .load_data_i(wdata_i),
    .byte_done_i(tx_byte_done_i),
    .byte_i(tx_byte_i),
    .sum_o(tx_checksum_sum)
  );

  ubac_csum u_rx_sum (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .en_i(checksum_adders_enable),
    .load_i(wr_rxs),
    .load_data_i(wdata_i),
    .byte_done_i(rx_byte_done_i),
    .byte_i(rx_byte_i),
    .sum_o(rx_checksum_sum)
  );

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  property p_cerr_lin;
    $rose(checksum_error_flag) |-> $past(mode_lin);
  endproperty
  a_cerr_lin: assert property (p_cerr_lin) else $error("checksum error outside LIN");

  property p_div_clear;
    (wr_lo || wr_hi) |=> (baud_count == 16'h0000) && !baud_tick_o;
  endproperty
  a_div_clear: assert property (p_div_clear) else $error("divisor write kept timer");

  property p_baud_tick;
    (ce_i && baud_wrap && !div_write) |=> baud_tick_o ##1 (baud_count != 16'h0000 || !ce_i
      || baud_divisor == 16'h0000 || $past(div_write));
  endproperty
  a_baud_tick: assert property (p_baud_tick) else $error("baud tick misplaced");

  property p_hold_meas;
    (rate_state == ubac_pkg::RATE_MEAS) |-> rx_sm_hold_o && !receiver_idle_o;
  endproperty
  a_hold_meas: assert property (p_hold_meas) else $error("receiver not held");

  property p_rate_load;
    (ce_i && rate_fifth_fall && !rate_count[16] && rate_req) |=>
      autobaud_done_flag && !autobaud_enable && baud_divisor == $past(rate_count[15:0]);
  endproperty
  a_rate_load: assert property (p_rate_load) else $error("auto-baud load wrong");

  property p_rate_ovf;
    (ce_i && rate_fifth_fall && rate_count[16]) |=>
      autobaud_done_flag && baud_divisor == $past(baud_divisor);
  endproperty
  a_rate_ovf: assert property (p_rate_ovf) else $error("overflow changed divisor");

  property p_idle_drop;
    (ce_i && rate_state == ubac_pkg::RATE_WAIT && rate_req && rx_fall) |=> !receiver_idle_o;
  endproperty
  a_idle_drop: assert property (p_idle_drop) else $error("idle did not drop");

  property p_coll;
    (ce_i && coll_check && rx_byte_done_i && coll_armed && rx_byte_i != tx_last) |=>
      collision_flag ##0 (collision_irq_o == $past(collision_irq_enable));
  endproperty
  a_coll: assert property (p_coll) else $error("collision missed");

  property p_holdoff;
    (ce_i && line_edge) |=> holdoff_restart_o;
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("activity restart missed");

  c_rate_done: cover property ((rate_state == ubac_pkg::RATE_TAIL) ##[1:1000] autobaud_done_flag);
  c_coll: cover property ($rose(collision_flag));
  c_bit: cover property (bit_tick_o ##[1:100] bit_tick_o);
  c_ovf: cover property ($rose(autobaud_overflow_flag));
endmodule

// File: ubac_remote.sv
// Remote serial sender model driving the receive line of the support block
`timescale 1ns/1ps
module ubac_remote (
  // Clock
  input wire logic clk_i,
  // Frame request
  input wire logic go_i,
  input wire logic [7:0] byte_i,
  input wire logic [15:0] bit_clks_i,
  // Serial line
  output logic line_o,
  output logic busy_o
);
  logic [9:0] frame;
  initial begin
    line_o = 1'b1;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i === 1'b1) begin
        // Start bit, data lsb first, stop bit
        frame = {1'b1, byte_i, 1'b0};
        busy_o <= 1'b1;
        for (int i = 0; i < 10; i++) begin
          line_o <= frame[i];
          repeat (bit_clks_i) @(posedge clk_i);
        end
        busy_o <= 1'b0;
      end
    end
  end
endmodule

// File: tb.sv
// Self-checking bench for the UART support block
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic tx_pin_i = 1'b1;
  logic tx_active_i = 1'b0;
  logic rx_sm_idle = 1'b1;
  logic [4:0] ev = 5'h00;
  logic [7:0] bt = 8'h00;
  logic go = 1'b0;
  logic [15:0] bit_clks = 16'h0028;
  logic [7:0] rdata_o;
  logic rx_line, busy, baud_tick_o, bit_tick_o, rx_sm_hold_o, receiver_idle_o;
  logic collision_irq_o, holdoff_restart_o;
  logic [15:0] expq[$];
  logic rd_q = 1'b0;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  int ho_cnt = 0;
  logic [7:0] abc[3] = '{8'hc0, 8'h40, 8'h8c};
  logic [15:0] abt[3] = '{16'd42, 16'd40, 16'd42};
  logic [7:0] abe[3] = '{8'h0a, 8'h02, 8'h0a};

  ubac_top dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_pin_i(rx_line),
    .tx_pin_i(tx_pin_i), .tx_byte_done_i(ev[0]), .tx_byte_i(bt), .rx_byte_done_i(ev[1]),
    .rx_byte_i(bt), .tx_active_i(tx_active_i), .dali_midbit_miss_i(ev[2]),
    .lin_sync_start_i(ev[4]), .lin_checksum_bad_i(ev[3]), .rx_sm_idle_i(rx_sm_idle),
    .baud_tick_o(baud_tick_o), .bit_tick_o(bit_tick_o), .rx_sm_hold_o(rx_sm_hold_o),
    .receiver_idle_o(receiver_idle_o), .collision_irq_o(collision_irq_o),
    .holdoff_restart_o(holdoff_restart_o));
  ubac_remote remote (.clk_i(clk_i), .go_i(go), .byte_i(8'h55), .bit_clks_i(bit_clks),
    .line_o(rx_line), .busy_o(busy));

  always #25 clk_i = ~clk_i;
  always @(negedge clk_i) if (holdoff_restart_o === 1'b1) ho_cnt++;

  task automatic end_sim();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Read results checked one cycle after the strobe
  always @(posedge clk_i) begin
    logic [15:0] e;
    rd_q <= rd_i;
    cyc <= cyc + 1;
    if (rd_q) begin
      e = expq.pop_front();
      compares++;
      if (((rdata_o ^ e[7:0]) & e[15:8]) !== 8'h00) begin
        n_errors++;
        $display("[ERR] %0t read got %h want %h", $time, rdata_o, e[7:0]);
      end
    end
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk_i);
    expq.push_back({m, e});
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  task automatic pulse(input logic [4:0] m, input logic [7:0] b);
    @(posedge clk_i);
    ev <= m;
    bt <= b;
    @(posedge clk_i);
    ev <= 5'h00;
  endtask
  task automatic wait_tick(input logic sel, output logic [15:0] n);
    n = 16'h0000;
    do begin
      @(negedge clk_i);
      n++;
    end while ((sel ? bit_tick_o : baud_tick_o) !== 1'b1 && n < 16'h0800);
  endtask

  initial begin
    logic [7:0] d, s;
    logic c;
    logic [15:0] n;
    void'($urandom(32'h0931));
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    chk({receiver_idle_o, collision_irq_o, rx_sm_hold_o}, 16'h0004);
    wr(3'h7, 8'hff);
    for (int a = 0; a < 8; a++) rd(3'(a), (a == 5) ? 8'h10 : 8'h00, (a == 5) ? 8'h1f : 8'hff);
    // Baud timer period, bit length and divisor write restart
    for (int k = 0; k < 2; k++) begin
      d = 8'($urandom_range(6, 2));
      wr(ubac_pkg::ADDR_CTRL, {k[0], 7'h00});
      wr(ubac_pkg::ADDR_DIV_HI, 8'h00);
      wr(ubac_pkg::ADDR_DIV_LO, 8'hff);
      repeat (40) @(posedge clk_i);
      wr(ubac_pkg::ADDR_DIV_LO, d);
      wait_tick(1'b0, n);
      chk(16'(n <= {8'h00, d} + 16'h0003), 16'h0001);
      wait_tick(1'b0, n);
      chk(n, {8'h00, d} + 16'h0001);
      wait_tick(1'b1, n);
      wait_tick(1'b1, n);
      chk(n, ({8'h00, d} + 16'h0001) * (k ? 16'h0004 : 16'h0010));
    end
    // Checksum adders
    wr(ubac_pkg::ADDR_CTRL, 8'h00);
    wr(ubac_pkg::ADDR_CTRL2, 8'h01);
    wr(ubac_pkg::ADDR_TX_SUM, 8'h5a);
    rd(ubac_pkg::ADDR_TX_SUM, 8'h5a, 8'hff);
    wr(ubac_pkg::ADDR_TX_SUM, 8'h00);
    wr(ubac_pkg::ADDR_RX_SUM, 8'h00);
    s = 8'h00;
    repeat (4) begin
      d = 8'($urandom);
      pulse(5'h03, d);
      {c, s} = {1'b0, s} + {1'b0, d};
      s = s + {7'h00, c};
    end
    rd(ubac_pkg::ADDR_TX_SUM, s, 8'hff);
    pulse(5'h03, ~s);
    rd(ubac_pkg::ADDR_TX_SUM, 8'hff, 8'hff);
    rd(ubac_pkg::ADDR_RX_SUM, 8'hff, 8'hff);
    wr(ubac_pkg::ADDR_CTRL2, 8'h00);
    pulse(5'h03, 8'h12);
    rd(ubac_pkg::ADDR_RX_SUM, 8'hff, 8'hff);
    // Collision detection
    wr(ubac_pkg::ADDR_CTRL, 8'h30);
    wr(ubac_pkg::ADDR_CTRL2, 8'h02);
    pulse(5'h01, 8'h55);
    pulse(5'h02, 8'h55);
    rd(ubac_pkg::ADDR_STATUS, 8'h00, 8'h04);
    pulse(5'h01, 8'h55);
    pulse(5'h02, 8'h54);
    rd(ubac_pkg::ADDR_STATUS, 8'h04, 8'h04);
    @(negedge clk_i);
    chk(collision_irq_o, 1'b1);
    wr(ubac_pkg::ADDR_STATUS, 8'h00);
    @(negedge clk_i);
    chk(collision_irq_o, 1'b0);
    wr(ubac_pkg::ADDR_CTRL, 8'h20);
    pulse(5'h01, 8'h55);
    pulse(5'h02, 8'h54);
    rd(ubac_pkg::ADDR_STATUS, 8'h00, 8'h04);
    wr(ubac_pkg::ADDR_CTRL2, 8'h00);
    wr(ubac_pkg::ADDR_CTRL, 8'h38);
    tx_active_i <= 1'b1;
    pulse(5'h04, 8'h00);
    rd(ubac_pkg::ADDR_STATUS, 8'h04, 8'h04);
    @(negedge clk_i);
    chk(collision_irq_o, 1'b0);
    tx_active_i <= 1'b0;
    wr(ubac_pkg::ADDR_STATUS, 8'h00);
    // Checksum error flag by mode
    wr(ubac_pkg::ADDR_CTRL, 8'h00);
    pulse(5'h08, 8'h00);
    rd(ubac_pkg::ADDR_STATUS, 8'h00, 8'h08);
    wr(ubac_pkg::ADDR_CTRL, 8'h0c);
    pulse(5'h08, 8'h00);
    rd(ubac_pkg::ADDR_STATUS, 8'h08, 8'h08);
    wr(ubac_pkg::ADDR_STATUS, 8'h00);
    wr(ubac_pkg::ADDR_CTRL, 8'h41);
    rd(ubac_pkg::ADDR_CTRL, 8'h01, 8'h7f);
    // Auto-baud: two speeds in async mode, then LIN
    for (int k = 0; k < 3; k++) begin
      wr(ubac_pkg::ADDR_DIV_LO, 8'h07);
      wr(ubac_pkg::ADDR_DIV_HI, 8'h00);
      wr(ubac_pkg::ADDR_CTRL, abc[k]);
      if (k == 2) pulse(5'h10, 8'h00);
      @(posedge clk_i);
      bit_clks <= abt[k];
      go <= 1'b1;
      ho_cnt = 0;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (3 * abt[k]) @(posedge clk_i);
      rd(ubac_pkg::ADDR_DIV_LO, 8'h07, 8'hff);
      @(negedge clk_i);
      chk({rx_sm_hold_o, receiver_idle_o}, 16'h0002);
      while (busy === 1'b1) @(posedge clk_i);
      repeat (8) @(negedge clk_i);
      chk({rx_sm_hold_o, receiver_idle_o}, 16'h0001);
      chk(16'(ho_cnt), 16'h000a);
      rd(ubac_pkg::ADDR_DIV_LO, abe[k], 8'hfe);
      rd(ubac_pkg::ADDR_DIV_HI, 8'h00, 8'hff);
      rd(ubac_pkg::ADDR_CTRL, 8'h00, 8'h40);
      rd(ubac_pkg::ADDR_STATUS, 8'h01, 8'h03);
      wr(ubac_pkg::ADDR_STATUS, 8'h00);
      rd(ubac_pkg::ADDR_STATUS, 8'h00, 8'h01);
    end
    // Activity restart on the transmit line
    wr(ubac_pkg::ADDR_CTRL2, 8'h04);
    ho_cnt = 0;
    @(posedge clk_i);
    tx_pin_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    tx_pin_i <= 1'b1;
    repeat (8) @(negedge clk_i);
    chk(16'(ho_cnt), 16'h0002);
    rx_sm_idle <= 1'b0;
    repeat (2) @(negedge clk_i);
    chk(receiver_idle_o, 1'b0);
    repeat (4) @(posedge clk_i);
    end_sim();
  end
endmodule
